//--- rtl/od_decrypt_defs.vh
// Constants for the on-the-fly read decryptor.
// What this block does
// - Writes into regions go to memory unmodified
// - Counter is IV upper 100 bits, address 31:4
// - Keys of 128, 192 or 256 bits
// - Counter mode only, each 16-byte block independent
// - Two regions, each with its own key
// - Reads outside every region return raw data
// - Decryption invisible to the reading master
// - Key and IV bytes taken big-endian
`ifndef OD_DECRYPT_DEFS_VH
`define OD_DECRYPT_DEFS_VH
`define OD_NREG 2
`define OD_FIFO_DEPTH 32
`define OD_FIFO_AW 5
// Per-region offsets; region n sits at n * 0x40
`define OD_RG_START 4'h0
`define OD_RG_END 4'h1
`define OD_RG_CFG 4'h2
`define OD_RG_IV0 4'h4
`define OD_RG_KEY0 4'h8
`define OD_CTRL 8'h80
`define OD_STATUS 8'h84
// Config field positions and reset values
`define OD_CFG_EN 0
`define OD_CFG_KL_LO 1
`define OD_CFG_RST 3'h0
`define OD_CTRL_GO 0
`define OD_CTRL_RGN 1
// Key length codes
`define OD_KL_128 2'h0
`define OD_KL_192 2'h1
`define OD_KL_256 2'h2
// Cipher constants
`define OD_RCON_INIT 8'h01
`define OD_GF_POLY 8'h1b
`define OD_AFFINE_C 8'h63
`endif

//--- rtl/od_fifo.v
// Synchronous valid/ready FIFO with registered input ready.
`timescale 1ns/1ps
module od_fifo #(
   parameter W = 32,
   parameter D = 32,
   parameter AW = 5
) (
   input wire ref_clk_i, // System clock
   input wire srst_i, // Synchronous reset, high
   input wire in_valid_i, // Write side valid
   output wire in_ready_o, // Write side ready, from a flop
   input wire [W-1:0] in_data_i, // Write data
   output wire out_valid_o, // Head entry present
   input wire out_ready_i, // Drain side takes head
   output wire [W-1:0] out_data_o // Head entry
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp_reg;
   reg [AW-1:0] rp_reg;
   reg [AW:0] cnt_reg;
   reg rdy_reg;
   wire push;
   wire pop;
   wire [AW:0] cnt_next;

   // Handshakes on both sides
   assign push = in_valid_i & rdy_reg;
   assign pop = out_valid_o & out_ready_i;
   assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
   assign out_data_o = mem[rp_reg];
   assign in_ready_o = rdy_reg;
   assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // Pointers and count; ready is precomputed so it leaves a flop
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         wp_reg <= {AW{1'b0}};
         rp_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         rdy_reg <= 1'b1;
      end else begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= rp_reg + 1'b1;
         end
         cnt_reg <= cnt_next;
         rdy_reg <= (cnt_next != D[AW:0]);
      end
   end

   // Storage needs no reset
   always @(posedge ref_clk_i) begin
      if (push) begin
         mem[wp_reg] <= in_data_i;
      end
   end
endmodule // od_fifo

//--- rtl/od_decrypt.v
// Read-path AES-CTR decryptor with region table and key expansion.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "od_decrypt_defs.vh"
module od_decrypt (
   input wire ref_clk_i, // System clock, 40 MHz
   input wire srst_i, // Synchronous reset, high
   input wire cfg_we_i, // Register write strobe
   input wire cfg_re_i, // Register read strobe
   input wire [7:0] cfg_addr_i, // Register byte address
   input wire [31:0] cfg_wdata_i, // Register write data
   output reg [31:0] cfg_rdata_o, // Read data, cycle after strobe
   input wire rq_valid_i, // Master request valid
   input wire rq_we_i, // Master request is a write
   input wire [31:0] rq_addr_i, // Master byte address
   input wire [31:0] rq_wdata_i, // Master write data
   output wire rq_ready_o, // Request taken
   output reg rd_valid_o, // Read answer valid
   output reg [31:0] rd_data_o, // Read answer data
   input wire rd_ready_i, // Master takes answer
   output reg mem_req_o, // Memory request pulse
   output reg mem_we_o, // Memory request is a write
   output reg [31:0] mem_addr_o, // Memory byte address
   output reg [31:0] mem_wdata_o, // Memory write data
   input wire mem_rvalid_i, // Memory read data valid
   input wire [31:0] mem_rdata_i, // Memory read data
   output wire mem_rready_o // Read data can be buffered
);
   localparam S_IDLE = 3'b001;
   localparam S_EXP = 3'b010;
   localparam S_AES = 3'b100;

   reg [31:0] start_reg [0:`OD_NREG-1];
   reg [31:0] end_reg [0:`OD_NREG-1];
   reg [2:0] cfg_reg [0:`OD_NREG-1];
   reg [31:0] iv_reg [0:4*`OD_NREG-1];
   reg [31:0] key_reg [0:8*`OD_NREG-1];
   reg [31:0] rk_mem [0:64*`OD_NREG-1];
   reg [1:0] klen_reg [0:`OD_NREG-1];
   reg [`OD_NREG-1:0] keyok_reg;
   reg [2:0] state_reg;
   reg xpend_reg;
   reg xrgn_reg;
   reg [5:0] xi_reg;
   reg [2:0] xmod_reg;
   reg [7:0] rcon_reg;
   reg crgn_reg;
   reg [3:0] rnd_reg;
   reg [127:0] st_reg;
   reg [127:0] ks_reg;
   reg [27:0] ks_blk_reg;
   reg ks_rgn_reg;
   reg ks_ok_reg;
   integer n;

   // Small GF(2^8) helpers for the cipher and key schedule
   function [7:0] xt;
      input [7:0] a;
      begin
         xt = {a[6:0], 1'b0} ^ (a[7] ? `OD_GF_POLY : 8'h00);
      end
   endfunction

   function [7:0] gmul;
      input [7:0] a;
      input [7:0] b;
      reg [7:0] p;
      reg [7:0] q;
      integer i;
      begin
         p = 8'h00;
         q = a;
         for (i = 0; i < 8; i = i + 1) begin
            if (b[i]) p = p ^ q;
            q = xt(q);
         end
         gmul = p;
      end
   endfunction

   // S-box as inverse (x^254) plus affine map; avoids a 256-entry table
   function [7:0] sbox;
      input [7:0] x;
      reg [7:0] p;
      reg [7:0] r;
      integer i;
      begin
         p = x;
         r = 8'h01;
         for (i = 1; i < 8; i = i + 1) begin
            p = gmul(p, p);
            r = gmul(r, p);
         end
         sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
            ^ {r[3:0], r[7:4]} ^ `OD_AFFINE_C;
      end
   endfunction

   function [31:0] subword;
      input [31:0] w;
      begin
         subword = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
      end
   endfunction

   // Byte k of the state sits at bits 127-8k, as the standard orders it
   function [127:0] sub_shift;
      input [127:0] s;
      integer c;
      integer r;
      begin
         sub_shift = 128'h0;
         for (c = 0; c < 4; c = c + 1) begin
            for (r = 0; r < 4; r = r + 1) begin
               sub_shift[127-8*(4*c+r) -: 8] = sbox(s[127-8*(4*((c+r)%4)+r) -: 8]);
            end
         end
      end
   endfunction

   function [127:0] mixcols;
      input [127:0] s;
      reg [7:0] a0;
      reg [7:0] a1;
      reg [7:0] a2;
      reg [7:0] a3;
      integer c;
      begin
         mixcols = 128'h0;
         for (c = 0; c < 4; c = c + 1) begin
            a0 = s[127-32*c -: 8];
            a1 = s[119-32*c -: 8];
            a2 = s[111-32*c -: 8];
            a3 = s[103-32*c -: 8];
            mixcols[127-32*c -: 8] = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
            mixcols[119-32*c -: 8] = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
            mixcols[111-32*c -: 8] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
            mixcols[103-32*c -: 8] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
         end
      end
   endfunction

   // Inclusive bounds on both ends; needs enable and an expanded key
   function in_rgn;
      input [31:0] a;
      input [31:0] lo;
      input [31:0] hi;
      input en;
      begin
         in_rgn = en & (a >= lo) & (a <= hi);
      end
   endfunction

   // Address queue and data queue run in lock step, one entry per read
   wire a_in_rdy;
   wire a_vld;
   wire [29:0] a_head;
   wire d_vld;
   wire [31:0] d_head;
   wire take;
   wire pop;
   wire rd_take;
   assign rq_ready_o = a_in_rdy;
   assign take = rq_valid_i & a_in_rdy;
   assign rd_take = take & ~rq_we_i;

   od_fifo #(.W(30), .D(`OD_FIFO_DEPTH), .AW(`OD_FIFO_AW)) u_afifo (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .in_valid_i(rd_take),
      .in_ready_o(a_in_rdy),
      .in_data_i(rq_addr_i[31:2]),
      .out_valid_o(a_vld),
      .out_ready_i(pop),
      .out_data_o(a_head)
   );

   od_fifo #(.W(32), .D(`OD_FIFO_DEPTH), .AW(`OD_FIFO_AW)) u_dfifo (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .in_valid_i(mem_rvalid_i),
      .in_ready_o(mem_rready_o),
      .in_data_i(mem_rdata_i),
      .out_valid_o(d_vld),
      .out_ready_i(pop),
      .out_data_o(d_head)
   );

   // Region lookup for the head read; region 0 wins an overlap
   wire [31:0] h_addr = {a_head, 2'b00};
   wire hit0 = in_rgn(h_addr, start_reg[0], end_reg[0], cfg_reg[0][`OD_CFG_EN] & keyok_reg[0]);
   wire hit1 = in_rgn(h_addr, start_reg[1], end_reg[1], cfg_reg[1][`OD_CFG_EN] & keyok_reg[1]);
   wire hit = hit0 | hit1;
   wire h_rgn = ~hit0;
   wire ks_hit = ks_ok_reg & (ks_blk_reg == h_addr[31:4]) & (ks_rgn_reg == h_rgn);
   wire out_free = ~rd_valid_o | rd_ready_i;
   assign pop = a_vld & d_vld & out_free & (~hit | ks_hit);
   wire [127:0] ctr = {iv_reg[{h_rgn, 2'd0}], iv_reg[{h_rgn, 2'd1}], iv_reg[{h_rgn, 2'd2}],
      iv_reg[{h_rgn, 2'd3}][31:28], h_addr[31:4]};
   wire start_aes = (state_reg == S_IDLE) & ~xpend_reg & a_vld & hit & ~ks_hit;

   // Cipher round datapath; round keys read straight from the table
   wire [3:0] nr = 4'd10 + {1'b0, klen_reg[crgn_reg], 1'b0};
   wire [127:0] rkey = {rk_mem[{crgn_reg, rnd_reg, 2'd0}], rk_mem[{crgn_reg, rnd_reg, 2'd1}],
      rk_mem[{crgn_reg, rnd_reg, 2'd2}], rk_mem[{crgn_reg, rnd_reg, 2'd3}]};
   wire [127:0] ss = sub_shift(st_reg);
   wire [127:0] rnd_out = ((rnd_reg == nr) ? ss : mixcols(ss)) ^ rkey;
   wire [127:0] rk_first = {rk_mem[{h_rgn, 6'd0}], rk_mem[{h_rgn, 6'd1}],
      rk_mem[{h_rgn, 6'd2}], rk_mem[{h_rgn, 6'd3}]};

   // Key schedule step, one word a cycle
   wire [3:0] nk = 4'd4 + {1'b0, klen_reg[xrgn_reg], 1'b0};
   wire [5:0] xtot = {nr_x(klen_reg[xrgn_reg]), 2'b00} + 6'd4;
   wire [31:0] wprev = rk_mem[{xrgn_reg, xi_reg - 6'd1}];
   wire [31:0] wback = rk_mem[{xrgn_reg, xi_reg - {2'b00, nk}}];
   reg [31:0] wnew;

   function [3:0] nr_x;
      input [1:0] kl;
      begin
         nr_x = 4'd10 + {1'b0, kl, 1'b0};
      end
   endfunction

   always @* begin
      if (xi_reg < {2'b00, nk}) begin
         wnew = key_reg[{xrgn_reg, xi_reg[2:0]}];
      end else if (xmod_reg == 3'd0) begin
         wnew = wback ^ subword({wprev[23:0], wprev[31:24]}) ^ {rcon_reg, 24'h0};
      end else if (nk == 4'd8 && xmod_reg == 3'd4) begin
         wnew = wback ^ subword(wprev);
      end else begin
         wnew = wback ^ wprev;
      end
   end

   // Engine: key expansion and per-block keystream generation
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_reg <= S_IDLE;
         xi_reg <= 6'h00;
         xmod_reg <= 3'h0;
         rcon_reg <= `OD_RCON_INIT;
         crgn_reg <= 1'b0;
         rnd_reg <= 4'h0;
         st_reg <= 128'h0;
         ks_reg <= 128'h0;
         ks_blk_reg <= 28'h0;
         ks_rgn_reg <= 1'b0;
         ks_ok_reg <= 1'b0;
         keyok_reg <= {`OD_NREG{1'b0}};
         for (n = 0; n < `OD_NREG; n = n + 1) begin
            klen_reg[n] <= `OD_KL_128;
         end
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (xpend_reg) begin
                  klen_reg[xrgn_reg] <= cfg_reg[xrgn_reg][`OD_CFG_KL_LO+1:`OD_CFG_KL_LO];
                  keyok_reg[xrgn_reg] <= 1'b0;
                  ks_ok_reg <= 1'b0;
                  xi_reg <= 6'h00;
                  xmod_reg <= 3'h0;
                  rcon_reg <= `OD_RCON_INIT;
                  state_reg <= S_EXP;
               end else if (start_aes) begin
                  crgn_reg <= h_rgn;
                  ks_blk_reg <= h_addr[31:4];
                  ks_rgn_reg <= h_rgn;
                  st_reg <= ctr ^ rk_first;
                  rnd_reg <= 4'd1;
                  state_reg <= S_AES;
               end
            end
            S_EXP: begin
               rk_mem[{xrgn_reg, xi_reg}] <= wnew;
               if (xi_reg >= {2'b00, nk} && xmod_reg == 3'd0) begin
                  rcon_reg <= xt(rcon_reg);
               end
               xmod_reg <= ({1'b0, xmod_reg} == nk - 4'd1) ? 3'd0 : xmod_reg + 3'd1;
               xi_reg <= xi_reg + 6'd1;
               if (xi_reg == xtot - 6'd1) begin
                  keyok_reg[xrgn_reg] <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            S_AES: begin
               // Pure counter mode: no tag, any block stands alone
               st_reg <= rnd_out;
               rnd_reg <= rnd_reg + 4'd1;
               if (rnd_reg == nr) begin
                  ks_reg <= rnd_out;
                  ks_ok_reg <= ~cfg_we_i;
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
         // Any config write may change key or IV, so drop the cached block
         if (cfg_we_i) begin
            ks_ok_reg <= 1'b0;
         end
      end
   end

   // Memory side: writes pass straight through, reads forwarded as taken
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= 32'h0;
         mem_wdata_o <= 32'h0;
      end else begin
         mem_req_o <= take;
         if (take) begin
            mem_we_o <= rq_we_i;
            mem_addr_o <= rq_addr_i;
            mem_wdata_o <= rq_wdata_i;
         end
      end
   end

   // Answer register; little-endian word w uses keystream bits 32w+31:32w
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o <= 32'h0;
      end else if (pop) begin
         rd_valid_o <= 1'b1;
         rd_data_o <= hit ? d_head ^ ks_reg[32*a_head[1:0] +: 32] : d_head;
      end else if (rd_ready_i) begin
         rd_valid_o <= 1'b0;
      end
   end

   // Register file writes; the go bit queues expansion until the engine idles, but is dropped while an expansion runs
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         xpend_reg <= 1'b0;
         xrgn_reg <= 1'b0;
         for (n = 0; n < `OD_NREG; n = n + 1) begin
            start_reg[n] <= 32'h0;
            end_reg[n] <= 32'h0;
            cfg_reg[n] <= `OD_CFG_RST;
         end
      end else begin
         if (xpend_reg && state_reg == S_IDLE) begin
            xpend_reg <= 1'b0;
         end
         if (cfg_we_i && !cfg_addr_i[7]) begin
            case (cfg_addr_i[5:2])
               `OD_RG_START: start_reg[cfg_addr_i[6]] <= cfg_wdata_i;
               `OD_RG_END: end_reg[cfg_addr_i[6]] <= cfg_wdata_i;
               `OD_RG_CFG: cfg_reg[cfg_addr_i[6]] <= cfg_wdata_i[2:0];
               default: begin
               end
            endcase
         end else if (cfg_we_i && cfg_addr_i == `OD_CTRL && cfg_wdata_i[`OD_CTRL_GO]
            && state_reg != S_EXP && !xpend_reg) begin
            xpend_reg <= 1'b1;
            xrgn_reg <= cfg_wdata_i[`OD_CTRL_RGN];
         end
      end
   end

   // IV and key words; keys are write-only so software cannot read them back
   always @(posedge ref_clk_i) begin
      if (cfg_we_i && !cfg_addr_i[7] && cfg_addr_i[5:4] == 2'b01) begin
         iv_reg[{cfg_addr_i[6], cfg_addr_i[3:2]}] <= cfg_wdata_i;
      end
      if (cfg_we_i && !cfg_addr_i[7] && cfg_addr_i[5]) begin
         key_reg[{cfg_addr_i[6], cfg_addr_i[4:2]}] <= cfg_wdata_i;
      end
   end

   // Read data for one cycle after the strobe; unmapped reads give zero
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         cfg_rdata_o <= 32'h0;
      end else if (cfg_re_i) begin
         cfg_rdata_o <= 32'h0;
         if (!cfg_addr_i[7]) begin
            case (cfg_addr_i[5:2])
               `OD_RG_START: cfg_rdata_o <= start_reg[cfg_addr_i[6]];
               `OD_RG_END: cfg_rdata_o <= end_reg[cfg_addr_i[6]];
               `OD_RG_CFG: cfg_rdata_o <= {29'h0, cfg_reg[cfg_addr_i[6]]};
               4'h4, 4'h5, 4'h6, 4'h7:
                  cfg_rdata_o <= iv_reg[{cfg_addr_i[6], cfg_addr_i[3:2]}];
               default: cfg_rdata_o <= 32'h0;
            endcase
         end else if (cfg_addr_i == `OD_STATUS) begin
            cfg_rdata_o <= {27'h0, ks_ok_reg, keyok_reg, state_reg == S_AES,
               (state_reg == S_EXP) | xpend_reg};
         end
      end else begin
         cfg_rdata_o <= 32'h0;
      end
   end
endmodule // od_decrypt

//--- test/od_mem_model.sv
// Behavioural external memory facing the decryptor's memory port.
`timescale 1ns/1ps
module od_mem_model #(
   parameter logic [31:0] PAT = 32'h5a3c96e1 // Data pattern, arbitrary
) (
   input logic ref_clk_i, // System clock
   input logic srst_i, // Synchronous reset, high
   input logic mem_req_i, // Request pulse
   input logic mem_we_i, // Request is a write
   input logic [31:0] mem_addr_i, // Byte address
   input logic [31:0] mem_wdata_i, // Write data
   input logic mem_rready_i, // Decryptor can take data
   input logic slow_i, // Insert gaps between answers
   output logic mem_rvalid_o, // Read data valid
   output logic [31:0] mem_rdata_o, // Read data
   output logic [31:0] wr_addr_o, // Last write address
   output logic [31:0] wr_data_o, // Last write data
   output logic [7:0] wr_cnt_o // Writes seen
);
   logic [31:0] q [$];
   logic [1:0] gap;
   // Answers in order, held until taken; inverted once released so stale data never matches
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         q.delete();
         mem_rvalid_o <= 1'b0;
         mem_rdata_o <= 32'h0;
         gap <= 2'h0;
         wr_cnt_o <= 8'h00;
      end else begin
         if (mem_req_i && !mem_we_i) q.push_back(mem_addr_i);
         if (mem_req_i && mem_we_i) begin
            wr_addr_o <= mem_addr_i;
            wr_data_o <= mem_wdata_i;
            wr_cnt_o <= wr_cnt_o + 8'h01;
         end
         if (mem_rvalid_o && mem_rready_i) begin
            mem_rvalid_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            gap <= slow_i ? 2'h3 : 2'h0;
         end else if (!mem_rvalid_o && gap != 2'h0) gap <= gap - 2'h1;
         else if (!mem_rvalid_o && q.size() > 0) begin
            mem_rvalid_o <= 1'b1;
            mem_rdata_o <= q.pop_front() ^ PAT;
         end
      end
   end
endmodule // od_mem_model

//--- test/od_decrypt_sva.sv
// Concurrent checks on the decryptor's ports.
`timescale 1ns/1ps
module od_decrypt_sva (
   input wire ref_clk_i, // System clock
   input wire srst_i, // Synchronous reset, high
   input wire cfg_re_i, // Register read strobe
   input wire [7:0] cfg_addr_i, // Register address
   input wire [31:0] cfg_rdata_o, // Register read data
   input wire rq_valid_i, // Request valid
   input wire rq_we_i, // Request is a write
   input wire [31:0] rq_addr_i, // Request address
   input wire [31:0] rq_wdata_i, // Request write data
   input wire rq_ready_o, // Request taken
   input wire rd_valid_o, // Answer valid
   input wire [31:0] rd_data_o, // Answer data
   input wire rd_ready_i, // Answer taken
   input wire mem_req_o, // Memory request
   input wire mem_we_o, // Memory write flag
   input wire [31:0] mem_addr_o, // Memory address
   input wire [31:0] mem_wdata_o, // Memory write data
   input wire mem_rvalid_i, // Memory data valid
   input wire mem_rready_o // Memory data taken
);
   logic [15:0] got_cnt;
   logic [15:0] ans_cnt;
   wire rd_take = rq_valid_i && rq_ready_o && !rq_we_i;
   wire wr_take = rq_valid_i && rq_ready_o && rq_we_i;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // Fetched words and delivered answers; an answer may never outrun its fetch
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         got_cnt <= 16'h0000;
         ans_cnt <= 16'h0000;
      end else begin
         if (mem_rvalid_i && mem_rready_o) got_cnt <= got_cnt + 16'h0001;
         if (rd_valid_o && rd_ready_i) ans_cnt <= ans_cnt + 16'h0001;
      end
   end
   a_write_passes_through: assert property (
      wr_take |=> mem_req_o && mem_we_o && mem_addr_o == $past(rq_addr_i)
      && mem_wdata_o == $past(rq_wdata_i)) else $error("write not forwarded unmodified");
   a_read_fetch_addr: assert property (
      rd_take |=> mem_req_o && !mem_we_o && mem_addr_o == $past(rq_addr_i))
      else $error("read not fetched at its address");
   a_req_has_cause: assert property (
      mem_req_o |-> $past(rq_valid_i) && $past(rq_ready_o)) else $error("spurious memory request");
   a_cfg_data_quiet: assert property (
      !$past(cfg_re_i) |-> cfg_rdata_o == 32'h0) else $error("read data outside its cycle");
   a_key_hidden: assert property (
      cfg_re_i && cfg_addr_i < 8'h80 && cfg_addr_i[5] |=> cfg_rdata_o == 32'h0)
      else $error("key word readable");
   a_unmapped_zero: assert property (
      cfg_re_i && cfg_addr_i > 8'h84 |=> cfg_rdata_o == 32'h0) else $error("unmapped read not 0");
   a_answer_holds: assert property (
      rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
      else $error("answer dropped before taken");
   a_answer_fetched: assert property (
      rd_valid_o |-> got_cnt > ans_cnt) else $error("answer without fetched word");
   c_write: cover property (wr_take);
   c_answer: cover property ($rose(rd_valid_o));
   c_refused: cover property (rq_valid_i && !rq_ready_o);
   c_stalled: cover property (rd_valid_o && !rd_ready_i ##1 rd_valid_o);
endmodule // od_decrypt_sva
bind od_decrypt od_decrypt_sva u_od_decrypt_sva (.*);

//--- test/od_decrypt_tb.sv
// Self-checking bench for the read-path decryptor.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module od_decrypt_tb;
   localparam logic [31:0] MPAT = 32'h5a3c96e1;
   // Counter block of this address with IV below is a known cipher input
   localparam logic [31:0] SB = 32'hcddeeff0;
   localparam logic [127:0] IV = 128'h00112233445566778899aabbc7654321;
   localparam logic [255:0] KEY = 256'h000102030405060708090a0b0c0d0e0f101112131415161718191a1b1c1d1e1f;
   localparam logic [127:0] KS [3] = '{128'h69c4e0d86a7b0430d8cdb78070b4c55a,
      128'hdda97ca4864cdfe06eaf70a0ec0d7191, 128'h8ea2b7ca516745bfeafc49904b496089};
   int n_errors = 0;
   int check_count = 0;
   logic ref_clk_i = 0, srst_i = 1, cfg_we_i = 0, cfg_re_i = 0, rq_valid_i = 0, rq_we_i = 0;
   logic rd_ready_i = 1, slow = 0, rq_ready_o, rd_valid_o, mem_req_o, mem_we_o;
   logic mem_rvalid_i, mem_rready_o;
   logic [7:0] cfg_addr_i = 0, wr_cnt;
   logic [31:0] cfg_wdata_i = 0, rq_addr_i = 0, rq_wdata_i = 0, cfg_rdata_o, rd_data_o;
   logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, wr_addr, wr_data;
   logic [31:0] ansq [$];
   always #12.5 ref_clk_i = ~ref_clk_i;
   od_decrypt u_od_decrypt (.*);
   od_mem_model #(.PAT(MPAT)) u_od_mem_model (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
      .mem_wdata_i(mem_wdata_o), .mem_rready_i(mem_rready_o), .slow_i(slow),
      .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i), .wr_addr_o(wr_addr),
      .wr_data_o(wr_data), .wr_cnt_o(wr_cnt));
   // Collect every answer the master takes
   always @(posedge ref_clk_i) begin
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) ansq.push_back(rd_data_o);
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic fail_out(input string what);
      n_errors++;
      $display("Error %s expected done seen timeout", what);
      final_report();
   endtask
   // Register accesses leave a gap cycle so strobes are never assigned twice in one step
   task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
      cfg_we_i <= 1'b1;
      cfg_addr_i <= a;
      cfg_wdata_i <= d;
      @(posedge ref_clk_i);
      cfg_we_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
      cfg_re_i <= 1'b1;
      cfg_addr_i <= a;
      @(posedge ref_clk_i);
      cfg_re_i <= 1'b0;
      // Read data stand only until the next edge, so take them mid-cycle
      @(negedge ref_clk_i);
      d = cfg_rdata_o;
      @(posedge ref_clk_i);
   endtask
   // Holds the request until taken; the caller releases valid after the last one
   task automatic rq_put(input logic we, input logic [31:0] a, input logic [31:0] d);
      int i;
      rq_valid_i <= 1'b1;
      rq_we_i <= we;
      rq_addr_i <= a;
      rq_wdata_i <= d;
      for (i = 0; i < 200; i++) begin
         @(posedge ref_clk_i);
         if (rq_ready_o === 1'b1) break;
      end
      if (i == 200) fail_out("request");
   endtask
   task automatic wait_ans(input int n);
      int i;
      for (i = 0; i < 2000 && ansq.size() < n; i++) @(posedge ref_clk_i);
      if (ansq.size() < n) fail_out("answers");
   endtask
   task automatic rd_blk(input logic [31:0] a, input logic [127:0] ks, input string nm);
      int w;
      ansq.delete();
      for (w = 0; w < 4; w++) rq_put(1'b0, a + 32'(4 * w), 32'h0);
      rq_valid_i <= 1'b0;
      wait_ans(4);
      for (w = 0; w < 4; w++) `CHK(nm, (a + 32'(4 * w)) ^ MPAT ^ ks[32 * w +: 32], ansq[w])
   endtask
   task automatic ld_region(input int n, input logic [1:0] kl);
      logic [7:0] b;
      logic [31:0] st;
      int i;
      b = 8'(n * 64);
      cfg_wr(b, SB);
      cfg_wr(b + 8'h04, SB + 32'hc);
      for (i = 0; i < 4; i++) cfg_wr(b + 8'h10 + 8'(4 * i), IV[127 - 32 * i -: 32]);
      for (i = 0; i < 8; i++) cfg_wr(b + 8'h20 + 8'(4 * i), KEY[255 - 32 * i -: 32]);
      cfg_wr(b + 8'h08, {29'h0, kl, 1'b1});
      cfg_wr(8'h80, {30'h0, n[0], 1'b1});
      cfg_rd(8'h84, st);
      `CHK("expansion pending", 1'b1, st[0])
      for (i = 0; i < 100 && st[0] !== 1'b0; i++) cfg_rd(8'h84, st);
      if (i == 100) fail_out("key expansion");
      `CHK("key ready", 1'b1, st[2 + n])
   endtask
   task automatic t_reset;
      logic [31:0] d;
      `CHK("rq_ready_o", 1'b1, rq_ready_o)
      `CHK("mem_rready_o", 1'b1, mem_rready_o)
      `CHK("rd_valid_o", 1'b0, rd_valid_o)
      cfg_rd(8'h08, d);
      `CHK("region cfg reset", 32'h0, d)
      cfg_wr(8'h20, 32'hffffffff);
      cfg_rd(8'h20, d);
      `CHK("key readback", 32'h0, d)
      cfg_rd(8'hc0, d);
      `CHK("unmapped read", 32'h0, d)
      $display("t_reset done");
   endtask
   // Each key length in turn, then both regions live with region 0 winning
   task automatic t_keys;
      int k;
      rd_blk(SB, 128'h0, "no region yet");
      for (k = 0; k < 3; k++) begin
         if (k == 2) cfg_wr(8'h08, 32'h0);
         ld_region(k / 2, 2'(k));
         rd_blk(SB, KS[k], "keystream");
         rd_blk(SB, KS[k], "cached keystream");
      end
      rd_blk(SB + 32'h10, 128'h0, "above end");
      rd_blk(SB - 32'h10, 128'h0, "below start");
      cfg_wr(8'h08, 32'h3);
      rd_blk(SB, KS[1], "region 0 own key");
      $display("t_keys done");
   endtask
   task automatic t_write;
      logic [7:0] c;
      int i;
      c = wr_cnt;
      rq_put(1'b1, SB + 32'h4, 32'hdeadbeef);
      rq_valid_i <= 1'b0;
      for (i = 0; i < 20 && wr_cnt === c; i++) @(posedge ref_clk_i);
      `CHK("write address", SB + 32'h4, wr_addr)
      `CHK("write data", 32'hdeadbeef, wr_data)
      $display("t_write done");
   endtask
   // Stall the master and slow the memory until requests are refused, then drain
   task automatic t_fill;
      int n;
      int w;
      n = 0;
      ansq.delete();
      rd_ready_i <= 1'b0;
      slow <= 1'b1;
      rq_valid_i <= 1'b1;
      rq_we_i <= 1'b0;
      rq_addr_i <= 32'h80000000;
      for (w = 0; w < 80; w++) begin
         @(posedge ref_clk_i);
         if (rq_ready_o !== 1'b1) break;
         n++;
         rq_addr_i <= 32'h80000000 + 32'(4 * n);
      end
      `CHK("taken before refusal", 1'b1, n >= 32 && w < 80)
      rd_ready_i <= 1'b1;
      rq_put(1'b0, 32'h80000000 + 32'(4 * n), 32'h0);
      n++;
      rq_valid_i <= 1'b0;
      wait_ans(n);
      for (w = 0; w < n; w++) `CHK("drained word", (32'h80000000 + 32'(4 * w)) ^ MPAT, ansq[w])
      slow <= 1'b0;
      $display("t_fill done");
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset();
      t_keys();
      t_write();
      t_fill();
      final_report();
   end
endmodule // od_decrypt_tb
